// [rtl/psc_pkg.sv]
// Package with constants and types for the passive serial configuration port.
package psc_pkg;
   // Register byte offsets.
   localparam logic [7:0] PSC_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] PSC_LENGTH_OFFSET = 8'h04;
   localparam logic [7:0] PSC_STATUS_OFFSET = 8'h08;
   localparam logic [7:0] PSC_DATA_OFFSET = 8'h0c;
   // Control field positions and reset values.
   localparam int PSC_CTRL_FORCE_ERROR_BIT = 0;
   localparam logic [31:0] PSC_LENGTH_RESET = 32'h00010000;
   // Header of the stream: a sync byte, then an option byte.
   localparam logic [7:0] PSC_SYNC_BYTE = 8'h6a;
   localparam int PSC_HEADER_BITS = 16;
   localparam int PSC_OPT_STARTUP_DONE_BIT = 0;
   localparam int PSC_OPT_USER_CLOCK_BIT = 1;
   localparam int PSC_OPT_AUTO_RESTART_BIT = 2;
   // Times in their own units and the derived cycle counts at the system clock.
   localparam int PSC_CLOCK_MHZ = 250;
   localparam int PSC_POR_LONG_MS = 100;
   localparam int PSC_POR_SHORT_MS = 12;
   localparam int PSC_POR_LONG_CYCLES = PSC_CLOCK_MHZ * 1000 * PSC_POR_LONG_MS;
   localparam int PSC_POR_SHORT_CYCLES = PSC_CLOCK_MHZ * 1000 * PSC_POR_SHORT_MS;
   localparam int PSC_RESTART_US = 100;
   localparam int PSC_RESTART_CYCLES = PSC_CLOCK_MHZ * PSC_RESTART_US;
   localparam int PSC_OSC_MHZ = 10;
   localparam int PSC_OSC_DIV = PSC_CLOCK_MHZ / PSC_OSC_MHZ;
   localparam int PSC_INIT_OSC_CYCLES = 200;
   localparam int PSC_CFG_SERIAL_CLOCK_MAX_PERIOD_NS = 10;
   localparam int PSC_STARTUP_DELAY_NS = 4 * PSC_CFG_SERIAL_CLOCK_MAX_PERIOD_NS;
   localparam int PSC_STARTUP_DELAY_CYCLES = (PSC_STARTUP_DELAY_NS * PSC_CLOCK_MHZ + 999) / 1000;
   localparam int PSC_USER_CLOCK_CYCLES = 299;
   // Configuration stages.
   typedef enum logic [2:0] {
      PSC_POWER_ON,
      PSC_RESET,
      PSC_LOAD,
      PSC_ERROR,
      PSC_STARTUP_DELAY,
      PSC_INIT_OSC,
      PSC_INIT_USER,
      PSC_USER_MODE
   } psc_stage_type;
endpackage : psc_pkg

// [rtl/psc_top.sv]
// Passive serial configuration port with an APB register slave.
`timescale 1ns/10ps
// How it works
// - Power-on delay 100 ms or 12 ms by select.
// - Power-on: status low, user I/O tri-stated.
// - Weak pull-ups on after power-on unless disable pin high.
// - Stay in reset while request low.
// - Request rise releases status, starts loading.
// - Sample data on serial clock rise until done.
// - Release load complete after correct data.
// - Internal oscillator clocks initialization; serial clock ignored.
// - User clock option: delay, then 299 cycles.
// - Startup complete low after option, high at end.
// - User mode drops pull-ups, drives user I/O.
// - Serial clock may stall indefinitely; device tolerates.
// - Configuration error pulls status low, resets.
// - Auto-restart releases status after 100 us.
// - Request low in user mode forces reconfiguration.
// - Finished device enables next one in chain.
// - User clock enabled four serial periods after done.
module psc_top
   import psc_pkg::*;
#(
   parameter int POR_LONG_CYCLES = PSC_POR_LONG_CYCLES,
   parameter int POR_SHORT_CYCLES = PSC_POR_SHORT_CYCLES,
   parameter int RESTART_CYCLES = PSC_RESTART_CYCLES
) (
   // System clock and reset.
   input wire logic clock,
   input wire logic reset,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Configuration pins from the host.
   input wire logic config_request_n,
   input wire logic cfg_serial_clock,
   input wire logic serial_data_in,
   input wire logic user_startup_clock,
   input wire logic power_on_delay_select,
   input wire logic weak_pullup_disable_n,
   input wire logic chain_enable_n,
   // Open-drain status pins, output enable high while pulling low.
   output logic cfg_status_n_out,
   output logic cfg_status_n_oe,
   output logic load_complete_out,
   output logic load_complete_oe,
   output logic startup_complete_out,
   output logic startup_complete_oe,
   // Chain and user I/O control.
   output logic chain_enable_out_n,
   output logic user_io_enable,
   output logic weak_pullup_enable
);
   generate
      if (POR_LONG_CYCLES < 1 || POR_SHORT_CYCLES < 1 || RESTART_CYCLES < 1) begin : g_bad_count
         $error("psc_top: cycle counts must be at least one");
      end
   endgenerate

   // Two-flop synchronisers; a third stage gives the previous value of each clock pin.
   logic [6:0] sync_first;
   logic [6:0] sync_pin;
   logic serial_clock_prev;
   logic user_clock_prev;
   always_ff @(posedge clock) begin
      if (reset) begin
         sync_first <= 7'h7f;
         sync_pin <= 7'h7f;
         serial_clock_prev <= 1'b1;
         user_clock_prev <= 1'b1;
      end else begin
         sync_first <= {chain_enable_n, weak_pullup_disable_n, power_on_delay_select, user_startup_clock,
                        serial_data_in, cfg_serial_clock, config_request_n};
         sync_pin <= sync_first;
         serial_clock_prev <= sync_pin[1];
         user_clock_prev <= sync_pin[3];
      end
   end
   logic request_n_s;
   logic data_s;
   logic select_s;
   logic pullup_disable_n_s;
   logic chain_enable_n_s;
   logic serial_clock_rise;
   logic user_clock_rise;
   assign request_n_s = sync_pin[0];
   assign data_s = sync_pin[2];
   assign select_s = sync_pin[4];
   assign pullup_disable_n_s = sync_pin[5];
   assign chain_enable_n_s = sync_pin[6];
   assign serial_clock_rise = sync_pin[1] && !serial_clock_prev;
   assign user_clock_rise = sync_pin[3] && !user_clock_prev;

   // Register file state.
   logic [31:0] load_length;
   logic force_error;
   logic [31:0] next_load_length;
   logic next_force_error;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;

   // Configuration sequencer state.
   psc_stage_type stage;
   psc_stage_type next_stage;
   logic [31:0] count;
   logic [31:0] next_count;
   logic [31:0] bit_count;
   logic [31:0] next_bit_count;
   logic [31:0] shift;
   logic [31:0] next_shift;
   logic [2:0] options;
   logic [2:0] next_options;
   logic [4:0] osc_div;
   logic [4:0] next_osc_div;
   logic [7:0] error_count;
   logic [7:0] next_error_count;
   logic next_status_oe;
   logic next_done_oe;
   logic next_startup_oe;
   logic next_chain_out_n;
   logic next_io_enable;
   logic next_pullup;

   logic apb_write;
   assign apb_write = psel && penable && pready && pwrite;

   always_comb begin
      next_stage = stage;
      next_count = count;
      next_bit_count = bit_count;
      next_shift = shift;
      next_options = options;
      next_error_count = error_count;
      next_osc_div = (osc_div == 5'(PSC_OSC_DIV - 1)) ? 5'h00 : osc_div + 5'h01;
      unique case (stage)
         PSC_POWER_ON: begin
            next_count = count + 32'h00000001;
            if (count >= (select_s ? 32'(POR_SHORT_CYCLES) : 32'(POR_LONG_CYCLES)) - 32'h00000001) begin
               next_stage = PSC_RESET;
            end
         end
         PSC_RESET: begin
            next_bit_count = 32'h00000000;
            next_options = 3'h0;
            if (request_n_s) begin
               next_stage = PSC_LOAD;
            end
         end
         PSC_LOAD: begin
            if (force_error) begin
               next_stage = PSC_ERROR;
               next_count = 32'h00000000;
               next_error_count = error_count + 8'h01;
            end else if (serial_clock_rise && !chain_enable_n_s) begin
               next_shift = {data_s, shift[31:1]};
               next_bit_count = bit_count + 32'h00000001;
               if (bit_count == 32'(PSC_HEADER_BITS / 2 - 1) && next_shift[31:24] != PSC_SYNC_BYTE) begin
                  next_stage = PSC_ERROR;
                  next_count = 32'h00000000;
                  next_error_count = error_count + 8'h01;
               end else if (bit_count == 32'(PSC_HEADER_BITS - 1)) begin
                  next_options = next_shift[26:24];
               end
               if (next_bit_count >= load_length && next_bit_count >= 32'(PSC_HEADER_BITS)) begin
                  next_count = 32'h00000000;
                  next_stage = options[PSC_OPT_USER_CLOCK_BIT] ? PSC_STARTUP_DELAY : PSC_INIT_OSC;
               end
            end
         end
         PSC_ERROR: begin
            next_count = count + 32'h00000001;
            next_bit_count = 32'h00000000;
            if (options[PSC_OPT_AUTO_RESTART_BIT] && count >= 32'(RESTART_CYCLES) - 32'h00000001) begin
               next_stage = PSC_LOAD;
               next_options = 3'h0;
            end
         end
         PSC_STARTUP_DELAY: begin
            next_count = count + 32'h00000001;
            if (count >= 32'(PSC_STARTUP_DELAY_CYCLES - 1)) begin
               next_stage = PSC_INIT_USER;
               next_count = 32'h00000000;
            end
         end
         PSC_INIT_OSC: begin
            if (osc_div == 5'h00) begin
               next_count = count + 32'h00000001;
               if (count >= 32'(PSC_INIT_OSC_CYCLES - 1)) begin
                  next_stage = PSC_USER_MODE;
               end
            end
         end
         PSC_INIT_USER: begin
            if (user_clock_rise) begin
               next_count = count + 32'h00000001;
               if (count >= 32'(PSC_USER_CLOCK_CYCLES - 1)) begin
                  next_stage = PSC_USER_MODE;
               end
            end
         end
         PSC_USER_MODE: begin
            next_count = 32'h00000000;
         end
      endcase
      if (stage != PSC_POWER_ON && !request_n_s) begin
         next_stage = PSC_RESET;
         next_count = 32'h00000000;
      end
      next_status_oe = (next_stage == PSC_POWER_ON) || (next_stage == PSC_RESET)
                       || (next_stage == PSC_ERROR);
      next_done_oe = (next_stage == PSC_POWER_ON) || (next_stage == PSC_RESET)
                     || (next_stage == PSC_LOAD) || (next_stage == PSC_ERROR);
      next_startup_oe = next_options[PSC_OPT_STARTUP_DONE_BIT] && (next_stage != PSC_USER_MODE)
                        && (next_stage != PSC_RESET) && (next_stage != PSC_POWER_ON);
      next_chain_out_n = next_done_oe;
      next_io_enable = (next_stage == PSC_USER_MODE);
      next_pullup = !pullup_disable_n_s && (next_stage != PSC_POWER_ON)
                    && (next_stage != PSC_USER_MODE);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         stage <= PSC_POWER_ON;
         count <= 32'h00000000;
         bit_count <= 32'h00000000;
         shift <= 32'h00000000;
         options <= 3'h0;
         osc_div <= 5'h00;
         error_count <= 8'h00;
         cfg_status_n_oe <= 1'b1;
         load_complete_oe <= 1'b1;
         startup_complete_oe <= 1'b0;
         chain_enable_out_n <= 1'b1;
         user_io_enable <= 1'b0;
         weak_pullup_enable <= 1'b0;
      end else begin
         stage <= next_stage;
         count <= next_count;
         bit_count <= next_bit_count;
         shift <= next_shift;
         options <= next_options;
         osc_div <= next_osc_div;
         error_count <= next_error_count;
         cfg_status_n_oe <= next_status_oe;
         load_complete_oe <= next_done_oe;
         startup_complete_oe <= next_startup_oe;
         chain_enable_out_n <= next_chain_out_n;
         user_io_enable <= next_io_enable;
         weak_pullup_enable <= next_pullup;
      end
   end

   // APB slave: one wait state, so every access completes in its second cycle.
   always_comb begin
      next_load_length = load_length;
      next_force_error = 1'b0;
      next_pready = psel && penable && !pready;
      next_prdata = 32'h00000000;
      next_pslverr = 1'b0;
      if (psel && penable && !pready) begin
         unique case (paddr)
            PSC_CTRL_OFFSET: next_prdata = 32'h00000000;
            PSC_LENGTH_OFFSET: next_prdata = load_length;
            PSC_STATUS_OFFSET: next_prdata = {13'h0000, options, error_count, 5'h00, stage};
            PSC_DATA_OFFSET: next_prdata = shift;
            default: next_pslverr = 1'b1;
         endcase
      end
      if (apb_write && paddr == PSC_CTRL_OFFSET) begin
         next_force_error = pwdata[PSC_CTRL_FORCE_ERROR_BIT];
      end
      if (apb_write && paddr == PSC_LENGTH_OFFSET) begin
         next_load_length = pwdata;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         load_length <= PSC_LENGTH_RESET;
         force_error <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         cfg_status_n_out <= 1'b0;
         load_complete_out <= 1'b0;
         startup_complete_out <= 1'b0;
      end else begin
         load_length <= next_load_length;
         force_error <= next_force_error;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         cfg_status_n_out <= 1'b0;
         load_complete_out <= 1'b0;
         startup_complete_out <= 1'b0;
      end
   end
endmodule : psc_top

// [tb/psc_assertions.sv]
// Checker for the passive serial configuration port.
`timescale 1ns/10ps
module psc_assertions (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Watched ports.
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic config_request_n,
   input wire logic weak_pullup_disable_n,
   input wire logic cfg_status_n_oe,
   input wire logic load_complete_oe,
   input wire logic startup_complete_oe,
   input wire logic chain_enable_out_n,
   input wire logic user_io_enable,
   input wire logic weak_pullup_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_request_low;
      (!config_request_n) [*6];
   endsequence
   sequence s_access_wait;
      psel && penable && !pready;
   endsequence
   chk_reset_stage: assert property (s_request_low |-> cfg_status_n_oe && load_complete_oe)
      else $error("status or done released while request low");
   chk_reset_io: assert property (s_request_low |-> !user_io_enable)
      else $error("user io driven while request low");
   chk_pullup_off: assert property (weak_pullup_disable_n [*5] |-> !weak_pullup_enable)
      else $error("pull-ups on while disabled");
   chk_user_pins: assert property (user_io_enable |-> !weak_pullup_enable && !cfg_status_n_oe && !load_complete_oe)
      else $error("user mode with pull-ups or low status");
   chk_chain_next: assert property ($fell(load_complete_oe) |-> ##[0:1] !chain_enable_out_n)
      else $error("chain enable late after loading");
   chk_startup_end: assert property ($rose(user_io_enable) |-> !startup_complete_oe)
      else $error("startup pin still low in user mode");
   chk_apb_wait: assert property (s_access_wait |=> pready && $past(psel))
      else $error("ready not after one wait state");
   chk_slave_error: assert property (pslverr |-> pready ##1 !pready)
      else $error("error without a one-cycle ready");
endmodule : psc_assertions
bind psc_top psc_assertions u_chk (.clock, .reset, .psel, .penable, .pready, .pslverr, .config_request_n,
   .weak_pullup_disable_n, .cfg_status_n_oe, .load_complete_oe, .startup_complete_oe, .chain_enable_out_n,
   .user_io_enable, .weak_pullup_enable);

// [tb/psc_host.sv]
// Model of the host that loads the configuration stream.
`timescale 1ns/10ps
module psc_host (
   // Clock that paces every pin change of the host.
   input wire logic clock,
   // Pins driven by the host.
   output logic config_request_n,
   output logic cfg_serial_clock,
   output logic serial_data_in,
   output logic user_startup_clock,
   // Status line as seen on the board.
   input wire logic cfg_status_n
);
   initial begin
      config_request_n = 1'b0;
      cfg_serial_clock = 1'b0;
      serial_data_in = 1'b0;
      user_startup_clock = 1'b0;
   end
   // Waits a number of rising clock edges; automatic so that parallel callers do not share it.
   task automatic wait_edges(input int k);
      repeat (k) @(posedge clock);
   endtask : wait_edges
   // Holds the request low long enough to reset the device.
   task drop;
      @(posedge clock);
      config_request_n <= 1'b0;
      wait_edges(500);
   endtask : drop
   // Raises the request, then waits for the status line before clocking.
   task start;
      @(posedge clock);
      config_request_n <= 1'b1;
      while (cfg_status_n !== 1'b1) @(posedge clock);
      wait_edges(500);
   endtask : start
   // Sends one byte, least significant bit first, at 160 ns a bit; the clock rests low afterwards.
   task send_byte(input logic [7:0] b);
      @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         serial_data_in <= b[i];
         wait_edges(20);
         cfg_serial_clock <= 1'b1;
         wait_edges(20);
         cfg_serial_clock <= 1'b0;
      end
   endtask : send_byte
   // Runs the user start-up clock at 25 MHz for a number of periods.
   task run_user(input int n);
      repeat (n) begin
         @(posedge clock);
         user_startup_clock <= 1'b1;
         wait_edges(5);
         user_startup_clock <= 1'b0;
         wait_edges(4);
      end
   endtask : run_user
endmodule : psc_host

// [tb/test_passive_serial_config_port.sv]
// Self-checking testbench for the passive serial configuration port.
`timescale 1ns/10ps
module test_passive_serial_config_port;
   import psc_pkg::*;
   logic clock, reset, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic power_on_delay_select, weak_pullup_disable_n, cfg_status_n_oe, load_complete_oe;
   logic config_request_n, cfg_serial_clock, serial_data_in, user_startup_clock;
   logic startup_complete_oe, chain_enable_out_n, user_io_enable, weak_pullup_enable;
   logic chain_enable_n, cfg_status_n_out, load_complete_out, startup_complete_out;
   int miscompares = 0;
   int n_checks = 0;
   int n;
   wire logic cfg_status_n = ~cfg_status_n_oe;
   psc_top #(.POR_LONG_CYCLES(100), .POR_SHORT_CYCLES(50), .RESTART_CYCLES(40)) DUT (.clock, .reset, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .config_request_n, .cfg_serial_clock,
      .serial_data_in, .user_startup_clock, .power_on_delay_select, .weak_pullup_disable_n, .chain_enable_n,
      .cfg_status_n_out, .cfg_status_n_oe, .load_complete_out, .load_complete_oe, .startup_complete_out,
      .startup_complete_oe, .chain_enable_out_n, .user_io_enable, .weak_pullup_enable);
   psc_host host (.clock, .config_request_n, .cfg_serial_clock, .serial_data_in, .user_startup_clock,
      .cfg_status_n);
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task end_of_test;
      if (miscompares == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task ticks(input int k);
      repeat (k) @(posedge clock);
   endtask : ticks
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      while (pready !== 1'b1) @(posedge clock);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task load(input logic [7:0] opt);
      host.send_byte(PSC_SYNC_BYTE);
      host.send_byte(opt);
      check("startup_oe", startup_complete_oe, opt[0]);
      host.send_byte(8'ha5);
      ticks(4);
      check("load_oe", load_complete_oe, 1'b0);
      check("chain_out", chain_enable_out_n, 1'b0);
      apb(1'b0, PSC_DATA_OFFSET, 32'h0, rd, err);
      check("data", rd[31:8], {8'ha5, opt, PSC_SYNC_BYTE});
   endtask : load
   task t_power_on;
      ticks(30);
      check("por_status", cfg_status_n_oe, 1'b1);
      check("por_io", user_io_enable, 1'b0);
      check("por_pullup", weak_pullup_enable, 1'b0);
      check("od_pins", {cfg_status_n_out, load_complete_out, startup_complete_out}, 3'b000);
      ticks(40);
      check("pullup_on", weak_pullup_enable, 1'b1);
      check("reset_status", cfg_status_n_oe, 1'b1);
      weak_pullup_disable_n <= 1'b1;
      ticks(10);
      check("pullup_off", weak_pullup_enable, 1'b0);
      weak_pullup_disable_n <= 1'b0;
      host.start();
      check("status_free", cfg_status_n_oe, 1'b0);
   endtask : t_power_on
   task t_registers;
      apb(1'b0, PSC_LENGTH_OFFSET, 32'h0, rd, err);
      check("length_reset", rd, PSC_LENGTH_RESET);
      apb(1'b1, PSC_LENGTH_OFFSET, 32'h18, rd, err);
      apb(1'b0, PSC_LENGTH_OFFSET, 32'h0, rd, err);
      check("length", rd, 32'h18);
      check("length_err", err, 1'b0);
      apb(1'b0, PSC_STATUS_OFFSET, 32'h0, rd, err);
      check("stage", rd[2:0], PSC_LOAD);
      apb(1'b0, 8'h10, 32'h0, rd, err);
      check("unmapped_data", rd, 32'h0);
      check("unmapped_err", err, 1'b1);
   endtask : t_registers
   task t_osc_init;
      load(8'h01);
      host.send_byte(8'h3c);
      ticks(4000);
      check("osc_early", user_io_enable, 1'b0);
      for (n = 0; n < 2000 && user_io_enable !== 1'b1; n++) ticks(1);
      check("user_mode", user_io_enable, 1'b1);
      check("startup_end", startup_complete_oe, 1'b0);
      check("pullup_gone", weak_pullup_enable, 1'b0);
      apb(1'b0, PSC_DATA_OFFSET, 32'h0, rd, err);
      check("data_kept", rd[31:8], 24'ha5016a);
   endtask : t_osc_init
   task t_reconfig;
      host.drop();
      check("rst_status", cfg_status_n_oe, 1'b1);
      check("rst_done", load_complete_oe, 1'b1);
      check("rst_io", user_io_enable, 1'b0);
      host.start();
      check("restart", cfg_status_n_oe, 1'b0);
   endtask : t_reconfig
   task t_user_clock;
      load(8'h03);
      fork
         host.drop();
         host.run_user(60);
      join
      check("init_abort", {cfg_status_n_oe, load_complete_oe, startup_complete_oe, user_io_enable}, 4'b1100);
      host.start();
      load(8'h03);
      host.run_user(298);
      check("user_early", user_io_enable, 1'b0);
      check("startup_low", startup_complete_oe, 1'b1);
      host.run_user(1);
      check("user_late", user_io_enable, 1'b1);
      check("startup_high", startup_complete_oe, 1'b0);
   endtask : t_user_clock
   task t_errors;
      host.send_byte(8'h00);
      ticks(4);
      check("sync_err", cfg_status_n_oe, 1'b1);
      ticks(200);
      check("no_restart", cfg_status_n_oe, 1'b1);
      t_reconfig();
      host.send_byte(PSC_SYNC_BYTE);
      host.send_byte(8'h04);
      apb(1'b1, PSC_CTRL_OFFSET, 32'h1, rd, err);
      ticks(30);
      check("forced_err", cfg_status_n_oe, 1'b1);
      for (n = 0; n < 30 && cfg_status_n_oe !== 1'b0; n++) ticks(1);
      check("auto_restart", cfg_status_n_oe, 1'b0);
      ticks(500);
      load(8'h00);
   endtask : t_errors
   task t_long_por;
      power_on_delay_select <= 1'b0;
      chain_enable_n <= 1'b1;
      reset <= 1'b1;
      ticks(6);
      reset <= 1'b0;
      ticks(90);
      check("long_por", {cfg_status_n_oe, weak_pullup_enable}, 2'b10);
      ticks(20);
      check("long_por_end", {cfg_status_n_oe, weak_pullup_enable}, 2'b01);
      ticks(500);
      host.send_byte(8'h00);
      ticks(4);
      check("chain_hold", cfg_status_n_oe, 1'b0);
      apb(1'b0, PSC_DATA_OFFSET, 32'h0, rd, err);
      check("chain_data", rd, 32'h0);
      chain_enable_n <= 1'b0;
      host.send_byte(8'h00);
      ticks(4);
      check("chain_take", cfg_status_n_oe, 1'b1);
   endtask : t_long_por
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      power_on_delay_select = 1'b1;
      weak_pullup_disable_n = 1'b0;
      chain_enable_n = 1'b0;
      ticks(6);
      reset <= 1'b0;
      t_power_on();
      t_registers();
      t_osc_init();
      t_reconfig();
      t_user_clock();
      t_reconfig();
      t_errors();
      t_long_por();
      end_of_test();
   end
   initial begin
      #200000;
      miscompares++;
      end_of_test();
   end
endmodule : test_passive_serial_config_port
